// *** verilog/bsfs_pkg.sv ***
// Constants, indices and states of the buck start-up and fault sequencer
package bsfs_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned OC_BLANK_NS    = 160;
  localparam int unsigned OC_BLANK_CYC_I =
    (OC_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [5:0]  OC_BLANK_CYC   = OC_BLANK_CYC_I[5:0];

  // Switching-cycle counts and the full-width ramp step
  localparam logic [12:0] HICCUP_CYC     = 13'h1000;
  localparam logic [8:0]  PG_DELAY_CYC   = 9'h100;
  localparam logic [5:0]  PB_STEP0_CYC   = 6'h20;
  localparam logic [5:0]  PB_STEP1_CYC   = 6'h10;
  localparam logic [5:0]  PB_STEP2_CYC   = 6'h08;
  localparam logic [1:0]  PB_STEP_FULL   = 2'h3;

  // Off-time measurement width
  localparam int unsigned OFF_W          = 16;

  // Comparator vector layout
  localparam int unsigned CMP_W          = 11;
  localparam int unsigned I_VCC_OK       = 0;
  localparam int unsigned I_EN_OK        = 1;
  localparam int unsigned I_OC_LOW       = 2;
  localparam int unsigned I_OV_TRIP      = 3;
  localparam int unsigned I_TEMP_HOT     = 4;
  localparam int unsigned I_PG_WIN       = 5;
  localparam int unsigned I_SS_LOW       = 6;
  localparam int unsigned I_SS_DELAY     = 7;
  localparam int unsigned I_TRACK_ABOVE  = 8;
  localparam int unsigned I_PWM_ON       = 9;
  localparam int unsigned I_OSC          = 10;

  // Sequencer states
  typedef enum logic [2:0] {
    BSFS_OFF      = 3'h0,
    BSFS_RUN      = 3'h1,
    BSFS_HICCUP   = 3'h2,
    BSFS_THERMAL  = 3'h3,
    BSFS_OV_HOLD  = 3'h4,
    BSFS_OV_LATCH = 3'h5,
    BSFS_SS_HOLD  = 3'h6
  } bsfs_state_t;

endpackage

// *** verilog/bsfs_cmp_if.sv ***
// Raw and synchronised comparator vector between core and synchroniser
`timescale 1ns/1ps
interface bsfs_cmp_if;
  logic [bsfs_pkg::CMP_W-1:0] raw;
  logic [bsfs_pkg::CMP_W-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface

// *** verilog/bsfs_sync.sv ***
// Three-stage comparator synchroniser with second/third agreement
`timescale 1ns/1ps
module bsfs_sync (
  input  wire logic  clock,
  input  wire logic  rst,
  bsfs_cmp_if.sync   cmp
);

  logic [bsfs_pkg::CMP_W-1:0] s1_r;
  logic [bsfs_pkg::CMP_W-1:0] s2_r;
  logic [bsfs_pkg::CMP_W-1:0] s3_r;
  logic [bsfs_pkg::CMP_W-1:0] clean_r;

  // Stage chain; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= {bsfs_pkg::CMP_W{1'b0}};
      s2_r <= {bsfs_pkg::CMP_W{1'b0}};
      s3_r <= {bsfs_pkg::CMP_W{1'b0}};
    end else begin
      s1_r <= cmp.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes only once two stages agree, filtering single glitches
  genvar g;
  generate
    for (g = 0; g < bsfs_pkg::CMP_W; g = g + 1) begin : g_agree
      always_ff @(posedge clock) begin
        if (rst) begin
          clean_r[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          clean_r[g] <= s3_r[g]; // RULE_23
        end
      end
    end
  endgenerate

  assign cmp.clean = clean_r;

endmodule

// *** verilog/bsfs_top.sv ***
// Buck start-up, protection and power-good sequencer core
//
// Function
// RULE_01 - Low side stays off at start until first high-side pulse issued.
// RULE_02 - Low-side width then ramps 25, 50, 75 percent, then full.
// RULE_03 - Ramp steps last 32, 16, then 8 low-side pulses.
// RULE_04 - Soft start begins only when supply and enable both report ready.
// RULE_05 - Overcurrent stays armed throughout the soft-start ramp.
// RULE_06 - Enable low puts both gate drivers in high impedance.
// RULE_07 - External soft-start pull-down stops output until node released.
// RULE_08 - Overcurrent when limit node is below ground while low side on.
// RULE_09 - Overcurrent latches a flag and enters hiccup, restarting soft start.
// RULE_10 - Hiccup discharges soft start for 4096 cycles, clears flag, restarts.
// RULE_11 - Hiccup repeats while overload persists; regulation resumes after.
// RULE_12 - Overcurrent sampling blanked 160 ns after low-side gate rises.
// RULE_13 - Over-temperature turns both switches off, discharges soft start.
// RULE_14 - Thermal shutdown restarts via soft start once temperature recovers.
// RULE_15 - Tracking reference hands over to fixed reference past crossover.
// RULE_16 - Power good true only while sense input is inside window.
// RULE_17 - Power good is open drain, released high when in regulation.
// RULE_18 - Non-tracking power good waits for soft-start delay level.
// RULE_19 - Power good needs 256 in-window switching cycles first.
// RULE_20 - Overvoltage holds high side off, low side on until release.
// RULE_21 - After overvoltage both drivers latch off until supply/enable cycle.
// RULE_22 - Both drivers held off whenever either lockout reports low.
// RULE_23 - Comparator results are synchronised before use.
// RULE_24 - Loss of power-on-ready clears all sequencer state.
`timescale 1ns/1ps
module bsfs_top (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic vcc_ok,
  input  wire logic enable_ok,
  input  wire logic oc_below_gnd,
  input  wire logic ov_trip,
  input  wire logic temp_hot,
  input  wire logic pg_in_window,
  input  wire logic ss_below_low,
  input  wire logic ss_delay_reached,
  input  wire logic track_above_crossover,
  input  wire logic pwm_on,
  input  wire logic osc_clk,
  input  wire logic tracking_mode,
  output logic      hs_gate,
  output logic      ls_gate,
  output logic      drivers_enabled,
  output logic      ss_discharge,
  output logic      ref_fixed,
  output logic      power_good_out,
  output logic      power_good_oe,
  output logic      overcurrent_protect,
  output logic      overvoltage_protect,
  output logic      thermal_shutdown
);

  bsfs_cmp_if cmp ();

  bsfs_pkg::bsfs_state_t state_r;

  logic                       por;
  logic                       tick;
  logic                       osc_d_r;
  logic                       oc_hit;
  logic                       hic_done;
  logic                       pg_qual;
  logic                       ls_permit;
  logic                       ext_ss_stop;
  logic                       hs_gate_r;
  logic                       ls_gate_r;
  logic                       drv_en_r;
  logic                       ss_dis_r;
  logic                       ref_fixed_r;
  logic                       pg_oe_r;
  logic                       pg_level_r;
  logic                       oc_flag_r;
  logic                       ov_flag_r;
  logic                       therm_r;
  logic                       first_hs_r;
  logic                       ss_seen_high_r;
  logic [1:0]                 step_r;
  logic [5:0]                 step_cnt_r;
  logic [5:0]                 blank_cnt_r;
  logic [12:0]                hic_cnt_r;
  logic [8:0]                 pg_cnt_r;
  logic [bsfs_pkg::OFF_W-1:0] off_cnt_r;
  logic [bsfs_pkg::OFF_W-1:0] off_len_r;
  logic                       pwm_d_r;

  // Length of a pre-bias ramp step in switching cycles
  function automatic logic [5:0] step_len(input logic [1:0] step);
    unique case (step)
      2'h0:    step_len = bsfs_pkg::PB_STEP0_CYC;
      2'h1:    step_len = bsfs_pkg::PB_STEP1_CYC;
      default: step_len = bsfs_pkg::PB_STEP2_CYC;
    endcase
  endfunction

  // Comparator inputs cross into the clock domain
  assign cmp.raw[bsfs_pkg::I_VCC_OK]      = vcc_ok;
  assign cmp.raw[bsfs_pkg::I_EN_OK]       = enable_ok;
  assign cmp.raw[bsfs_pkg::I_OC_LOW]      = oc_below_gnd;
  assign cmp.raw[bsfs_pkg::I_OV_TRIP]     = ov_trip;
  assign cmp.raw[bsfs_pkg::I_TEMP_HOT]    = temp_hot;
  assign cmp.raw[bsfs_pkg::I_PG_WIN]      = pg_in_window;
  assign cmp.raw[bsfs_pkg::I_SS_LOW]      = ss_below_low;
  assign cmp.raw[bsfs_pkg::I_SS_DELAY]    = ss_delay_reached;
  assign cmp.raw[bsfs_pkg::I_TRACK_ABOVE] = track_above_crossover;
  assign cmp.raw[bsfs_pkg::I_PWM_ON]      = pwm_on;
  assign cmp.raw[bsfs_pkg::I_OSC]         = osc_clk;

  bsfs_sync u_sync (
    .clock (clock),
    .rst   (rst),
    .cmp   (cmp.sync)
  );

  // Power-on-ready needs both lockout comparators high
  assign por = cmp.clean[bsfs_pkg::I_VCC_OK] &
               cmp.clean[bsfs_pkg::I_EN_OK]; // RULE_04

  // One switching cycle per rising oscillator edge
  assign tick = cmp.clean[bsfs_pkg::I_OSC] & ~osc_d_r;

  // Overcurrent sampled only after blanking, while the low side conducts
  assign oc_hit = ls_gate_r && (blank_cnt_r == bsfs_pkg::OC_BLANK_CYC) &&
                  cmp.clean[bsfs_pkg::I_OC_LOW]; // RULE_08 RULE_12

  assign hic_done = tick &&
                    (hic_cnt_r == bsfs_pkg::HICCUP_CYC - 13'h0001);

  // External pull-down only counts after the node has risen once
  assign ext_ss_stop = ss_seen_high_r && cmp.clean[bsfs_pkg::I_SS_LOW];

  // Tracking mode skips the soft-start delay comparator
  assign pg_qual = (state_r == bsfs_pkg::BSFS_RUN) &&
                   cmp.clean[bsfs_pkg::I_PG_WIN] && // RULE_16
                   (tracking_mode ||
                    cmp.clean[bsfs_pkg::I_SS_DELAY]); // RULE_18

  // Low-side window: a fraction of last off time, full at final step
  assign ls_permit = (step_r == bsfs_pkg::PB_STEP_FULL) ||
                     ({2'b00, off_cnt_r} << 2) <
                     ({2'b00, off_len_r} *
                      {{bsfs_pkg::OFF_W{1'b0}}, step_r + 2'h1}); // RULE_02

  // Edge history for oscillator and PWM
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_d_r <= 1'b0;
      pwm_d_r <= 1'b0;
    end else begin
      osc_d_r <= cmp.clean[bsfs_pkg::I_OSC];
      pwm_d_r <= cmp.clean[bsfs_pkg::I_PWM_ON];
    end
  end

  // Main sequencer; lockout beats every fault, thermal beats overvoltage hold but not the overvoltage latch
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= bsfs_pkg::BSFS_OFF;
    end else if (!por) begin
      state_r <= bsfs_pkg::BSFS_OFF; // RULE_22 RULE_24
    end else begin
      unique case (state_r)
        bsfs_pkg::BSFS_OFF: begin
          state_r <= bsfs_pkg::BSFS_RUN; // RULE_04
        end
        bsfs_pkg::BSFS_RUN: begin
          if (cmp.clean[bsfs_pkg::I_TEMP_HOT]) begin
            state_r <= bsfs_pkg::BSFS_THERMAL; // RULE_13
          end else if (cmp.clean[bsfs_pkg::I_OV_TRIP]) begin
            state_r <= bsfs_pkg::BSFS_OV_HOLD; // RULE_20
          end else if (oc_hit) begin
            state_r <= bsfs_pkg::BSFS_HICCUP; // RULE_05 RULE_09
          end else if (ext_ss_stop) begin
            state_r <= bsfs_pkg::BSFS_SS_HOLD; // RULE_07
          end
        end
        bsfs_pkg::BSFS_HICCUP: begin
          if (cmp.clean[bsfs_pkg::I_TEMP_HOT]) begin
            state_r <= bsfs_pkg::BSFS_THERMAL;
          end else if (hic_done) begin
            state_r <= bsfs_pkg::BSFS_RUN; // RULE_10 RULE_11
          end
        end
        bsfs_pkg::BSFS_THERMAL: begin
          if (!cmp.clean[bsfs_pkg::I_TEMP_HOT]) begin
            state_r <= bsfs_pkg::BSFS_RUN; // RULE_14
          end
        end
        bsfs_pkg::BSFS_OV_HOLD: begin
          if (cmp.clean[bsfs_pkg::I_TEMP_HOT]) begin
            state_r <= bsfs_pkg::BSFS_THERMAL;
          end else if (!cmp.clean[bsfs_pkg::I_OV_TRIP]) begin
            state_r <= bsfs_pkg::BSFS_OV_LATCH; // RULE_21
          end
        end
        bsfs_pkg::BSFS_OV_LATCH: begin
          state_r <= bsfs_pkg::BSFS_OV_LATCH; // RULE_21
        end
        bsfs_pkg::BSFS_SS_HOLD: begin
          if (cmp.clean[bsfs_pkg::I_TEMP_HOT]) begin
            state_r <= bsfs_pkg::BSFS_THERMAL;
          end else if (!cmp.clean[bsfs_pkg::I_SS_LOW]) begin
            state_r <= bsfs_pkg::BSFS_RUN; // RULE_07
          end
        end
        default: begin
          state_r <= bsfs_pkg::BSFS_OFF;
        end
      endcase
    end
  end

  // Soft-start node seen above its low level during this run
  always_ff @(posedge clock) begin
    if (rst || state_r != bsfs_pkg::BSFS_RUN) begin
      ss_seen_high_r <= 1'b0;
    end else if (!cmp.clean[bsfs_pkg::I_SS_LOW]) begin
      ss_seen_high_r <= 1'b1;
    end
  end

  // Last off-time length, the base for the ramped low-side width
  always_ff @(posedge clock) begin
    if (rst) begin
      off_cnt_r <= {bsfs_pkg::OFF_W{1'b0}};
      off_len_r <= {bsfs_pkg::OFF_W{1'b0}};
    end else if (cmp.clean[bsfs_pkg::I_PWM_ON]) begin
      off_cnt_r <= {bsfs_pkg::OFF_W{1'b0}};
      if (!pwm_d_r) begin
        off_len_r <= off_cnt_r; // Off time just ended, count is complete
      end
    end else begin
      if (off_cnt_r != {bsfs_pkg::OFF_W{1'b1}}) begin
        off_cnt_r <= off_cnt_r + 1'b1;
      end
    end
  end

  // Pre-bias ramp: wait for first high pulse, then stepped widths
  always_ff @(posedge clock) begin
    if (rst || state_r != bsfs_pkg::BSFS_RUN) begin
      first_hs_r <= 1'b0; // RULE_24
      step_r     <= 2'h0;
      step_cnt_r <= 6'h00;
    end else begin
      if (hs_gate_r) begin
        first_hs_r <= 1'b1; // RULE_01
      end
      if (first_hs_r && tick && step_r != bsfs_pkg::PB_STEP_FULL) begin
        if (step_cnt_r == step_len(step_r) - 6'h01) begin
          step_r     <= step_r + 2'h1; // RULE_03
          step_cnt_r <= 6'h00;
        end else begin
          step_cnt_r <= step_cnt_r + 6'h01;
        end
      end
    end
  end

  // Gate commands; overvoltage forces low side on, high side off
  always_ff @(posedge clock) begin
    if (rst) begin
      hs_gate_r <= 1'b0;
      ls_gate_r <= 1'b0;
    end else if (!por) begin
      hs_gate_r <= 1'b0; // RULE_22
      ls_gate_r <= 1'b0;
    end else begin
      unique case (state_r)
        bsfs_pkg::BSFS_RUN: begin
          hs_gate_r <= cmp.clean[bsfs_pkg::I_PWM_ON];
          ls_gate_r <= first_hs_r && ls_permit &&
                       !cmp.clean[bsfs_pkg::I_PWM_ON]; // RULE_01
        end
        bsfs_pkg::BSFS_OV_HOLD: begin
          hs_gate_r <= 1'b0; // RULE_20
          ls_gate_r <= 1'b1;
        end
        default: begin
          hs_gate_r <= 1'b0; // RULE_13 RULE_21
          ls_gate_r <= 1'b0;
        end
      endcase
    end
  end

  // Driver enable follows power-on-ready; low means high impedance
  always_ff @(posedge clock) begin
    if (rst) begin
      drv_en_r <= 1'b0;
    end else begin
      drv_en_r <= por; // RULE_06
    end
  end

  // Blanking count restarts on every low-side turn-on
  always_ff @(posedge clock) begin
    if (rst || !ls_gate_r) begin
      blank_cnt_r <= 6'h00;
    end else if (blank_cnt_r != bsfs_pkg::OC_BLANK_CYC) begin
      blank_cnt_r <= blank_cnt_r + 6'h01; // RULE_12
    end
  end

  // Overcurrent flag; a new hit wins over the hiccup clear
  always_ff @(posedge clock) begin
    if (rst || !por) begin
      oc_flag_r <= 1'b0; // RULE_24
    end else if (oc_hit && state_r == bsfs_pkg::BSFS_RUN) begin
      oc_flag_r <= 1'b1; // RULE_09
    end else if (hic_done && state_r == bsfs_pkg::BSFS_HICCUP) begin
      oc_flag_r <= 1'b0; // RULE_10
    end
  end

  // Hiccup off-time in switching cycles
  always_ff @(posedge clock) begin
    if (rst || state_r != bsfs_pkg::BSFS_HICCUP) begin
      hic_cnt_r <= 13'h0000; // RULE_24
    end else if (tick) begin
      hic_cnt_r <= hic_cnt_r + 13'h0001; // RULE_10
    end
  end

  // Soft-start discharge while off, in hiccup or over temperature
  always_ff @(posedge clock) begin
    if (rst) begin
      ss_dis_r <= 1'b1;
    end else begin
      ss_dis_r <= (state_r == bsfs_pkg::BSFS_OFF) ||
                  (state_r == bsfs_pkg::BSFS_HICCUP) || // RULE_10
                  (state_r == bsfs_pkg::BSFS_THERMAL); // RULE_13
    end
  end

  // Overvoltage and thermal status; latch cleared only by lockout
  always_ff @(posedge clock) begin
    if (rst || !por) begin
      ov_flag_r <= 1'b0;
      therm_r   <= 1'b0;
    end else begin
      therm_r <= (state_r == bsfs_pkg::BSFS_THERMAL);
      if (state_r == bsfs_pkg::BSFS_OV_HOLD) begin
        ov_flag_r <= 1'b1; // RULE_21
      end
    end
  end

  // Fixed reference always when not tracking; latched once crossed over
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_fixed_r <= 1'b0;
    end else if (!tracking_mode) begin
      ref_fixed_r <= 1'b1;
    end else if (state_r != bsfs_pkg::BSFS_RUN) begin
      ref_fixed_r <= 1'b0;
    end else if (cmp.clean[bsfs_pkg::I_TRACK_ABOVE]) begin
      ref_fixed_r <= 1'b1; // RULE_15
    end
  end

  // Power-good delay: qualified cycles, restarted on any drop-out
  always_ff @(posedge clock) begin
    if (rst || !pg_qual) begin
      pg_cnt_r <= 9'h000; // RULE_24
      pg_oe_r  <= 1'b1; // RULE_16
    end else begin
      if (tick && pg_cnt_r != bsfs_pkg::PG_DELAY_CYC) begin
        pg_cnt_r <= pg_cnt_r + 9'h001;
      end
      pg_oe_r <= (pg_cnt_r != bsfs_pkg::PG_DELAY_CYC); // RULE_19
    end
  end

  // Open-drain pin: pull low unless good, released level is zero data
  always_ff @(posedge clock) begin
    if (rst) begin
      pg_level_r <= 1'b0;
    end else begin
      pg_level_r <= 1'b0; // RULE_17
    end
  end

  assign hs_gate             = hs_gate_r;
  assign ls_gate             = ls_gate_r;
  assign drivers_enabled     = drv_en_r;
  assign ss_discharge        = ss_dis_r;
  assign ref_fixed           = ref_fixed_r;
  assign power_good_out      = pg_level_r;
  assign power_good_oe       = pg_oe_r; // RULE_17
  assign overcurrent_protect = oc_flag_r;
  assign overvoltage_protect = ov_flag_r;
  assign thermal_shutdown    = therm_r;

endmodule

// *** verif/bsfs_top_asserts.sv ***
// Concurrent port checks for the buck start-up and fault sequencer
`timescale 1ns/1ps
module bsfs_top_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic vcc_ok,
  input wire logic enable_ok,
  input wire logic oc_below_gnd,
  input wire logic ov_trip,
  input wire logic temp_hot,
  input wire logic pg_in_window,
  input wire logic ss_below_low,
  input wire logic ss_delay_reached,
  input wire logic track_above_crossover,
  input wire logic pwm_on,
  input wire logic osc_clk,
  input wire logic tracking_mode,
  input wire logic hs_gate,
  input wire logic ls_gate,
  input wire logic drivers_enabled,
  input wire logic ss_discharge,
  input wire logic ref_fixed,
  input wire logic power_good_out,
  input wire logic power_good_oe,
  input wire logic overcurrent_protect,
  input wire logic overvoltage_protect,
  input wire logic thermal_shutdown
);
  logic        osc_d_r;
  logic [12:0] hic_cnt_r;
  logic [9:0]  pg_cnt_r;
  logic [5:0]  ls_run_r;
  logic [4:0]  blank_r;
  logic        hs_seen_r;
  wire         por_w = vcc_ok && enable_ok;
  wire         rise_w = osc_clk && !osc_d_r;
  wire         pgq_w = pg_in_window && (ss_delay_reached || tracking_mode)
                 && por_w && !ss_discharge && !overcurrent_protect
                 && !thermal_shutdown && !overvoltage_protect;

  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);

  // Raw oscillator edge; the design sees it a few clocks later
  always_ff @(posedge clock) osc_d_r <= osc_clk;
  // Switching cycles spent in hiccup
  always_ff @(posedge clock) begin
    if (rst || !overcurrent_protect) hic_cnt_r <= 13'h0000;
    else if (rise_w) hic_cnt_r <= hic_cnt_r + 13'h0001;
  end
  // In-window cycles; runs ahead of the design, so only a floor is safe
  always_ff @(posedge clock) begin
    if (rst || !pgq_w) pg_cnt_r <= 10'h000;
    else if (rise_w && pg_cnt_r != 10'h3FF) pg_cnt_r <= pg_cnt_r + 10'h001;
  end
  // Low-side run length and a short grace after 32 clocks on
  always_ff @(posedge clock) begin
    if (rst || !ls_gate) ls_run_r <= 6'h00;
    else if (ls_run_r != 6'h3F) ls_run_r <= ls_run_r + 6'h01;
  end
  always_ff @(posedge clock) begin
    if (rst) blank_r <= 5'h00;
    else if (ls_gate && ls_run_r >= 6'h1F) blank_r <= 5'h10;
    else if (blank_r != 5'h00) blank_r <= blank_r - 5'h01;
  end
  // First high-side pulse since the last discharge or lockout
  always_ff @(posedge clock) begin
    if (rst || ss_discharge || !drivers_enabled) hs_seen_r <= 1'b0;
    else if (hs_gate) hs_seen_r <= 1'b1;
  end

  sequence s_lockout; (!por_w)[*8]; endsequence
  sequence s_hot; (temp_hot && por_w)[*8]; endsequence
  sequence s_ov_on; (ov_trip && por_w && !temp_hot)[*8]; endsequence
  sequence s_ov_gone; (!ov_trip && overvoltage_protect && por_w)[*8];
  endsequence

  a_lockout_off: assert property (
    s_lockout |-> !drivers_enabled && !hs_gate && !ls_gate)
    else $error("drivers active in lockout");
  a_thermal_off: assert property (
    s_hot |-> thermal_shutdown && ss_discharge && !hs_gate && !ls_gate)
    else $error("thermal shutdown not applied");
  a_ov_hold: assert property (
    s_ov_on |-> !hs_gate && ls_gate && overvoltage_protect)
    else $error("overvoltage hold wrong");
  a_ov_latch: assert property (
    s_ov_gone |-> !hs_gate && !ls_gate)
    else $error("overvoltage latch not off");
  a_hiccup_len: assert property (
    $fell(overcurrent_protect) && por_w
      |-> hic_cnt_r inside {[13'h0FFF:13'h1001]})
    else $error("hiccup length wrong");
  a_oc_blanked: assert property (
    $rose(overcurrent_protect) |-> blank_r != 5'h00)
    else $error("overcurrent inside blanking");
  a_prebias_ls: assert property (
    ls_gate && !overvoltage_protect |-> hs_seen_r)
    else $error("low side before first high pulse");
  a_pg_window: assert property (
    (!pg_in_window)[*8] |-> power_good_oe)
    else $error("power good outside window");
  a_pg_delay: assert property (
    $fell(power_good_oe) |-> pg_cnt_r >= 10'h0FF)
    else $error("power good too early");
  a_ref_fixed: assert property (
    (!tracking_mode)[*4] |-> ref_fixed)
    else $error("fixed reference not used");
endmodule

bind bsfs_top bsfs_top_asserts i_bsfs_top_asserts (.clock, .rst, .vcc_ok,
  .enable_ok, .oc_below_gnd, .ov_trip, .temp_hot, .pg_in_window,
  .ss_below_low, .ss_delay_reached, .track_above_crossover, .pwm_on,
  .osc_clk, .tracking_mode, .hs_gate, .ls_gate, .drivers_enabled,
  .ss_discharge, .ref_fixed, .power_good_out, .power_good_oe,
  .overcurrent_protect, .overvoltage_protect, .thermal_shutdown);

// *** verif/bsfs_plant.sv ***
// Oscillator, PWM comparator and power-good pull-up beside the sequencer
`timescale 1ns/1ps
module bsfs_plant (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [5:0] osc_half,
  input  wire logic [5:0] pwm_high,
  input  wire logic       power_good_out,
  input  wire logic       power_good_oe,
  output logic            osc_clk,
  output logic            pwm_on,
  output wire logic       pg_pin
);
  logic [6:0] phase_r;
  // Period change acts at once, like a resynchronised oscillator
  always_ff @(posedge clock) begin
    if (rst || phase_r >= {osc_half, 1'b0} - 7'h01) phase_r <= 7'h00;
    else phase_r <= phase_r + 7'h01;
  end
  // Square wave and PWM demand both start each switching cycle
  always_ff @(posedge clock) begin
    osc_clk <= phase_r < {1'b0, osc_half};
    pwm_on  <= phase_r < {1'b0, pwm_high};
  end
  // Board pull-up: a released pin reads high
  assign pg_pin = power_good_oe ? power_good_out : 1'b1;
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the buck start-up and fault sequencer
`timescale 1ns/1ps
module tb;
  localparam int LIMIT = 95000;
  logic        clock, rst = 1'b1, vcc_ok = 1'b0, enable_ok = 1'b0;
  logic        oc_below_gnd = 1'b0, ov_trip = 1'b0, temp_hot = 1'b0;
  logic        pg_in_window = 1'b0, ss_below_low = 1'b0;
  logic        ss_delay_reached = 1'b0, track_above_crossover = 1'b0;
  logic        tracking_mode = 1'b0, pwm_on, osc_clk, pg_pin;
  logic        hs_gate, ls_gate, drivers_enabled, ss_discharge, ref_fixed;
  logic        power_good_out, power_good_oe, overcurrent_protect;
  logic        overvoltage_protect, thermal_shutdown;
  logic [5:0]  osc_half = 6'h04, pwm_high = 6'h00;
  logic [15:0] c1, c2, c3;
  int          n_errors = 0, tests_run = 0, cycles = 0, k;

  bsfs_top i_bsfs_top (.clock, .rst, .vcc_ok, .enable_ok, .oc_below_gnd,
    .ov_trip, .temp_hot, .pg_in_window, .ss_below_low, .ss_delay_reached,
    .track_above_crossover, .pwm_on, .osc_clk, .tracking_mode, .hs_gate,
    .ls_gate, .drivers_enabled, .ss_discharge, .ref_fixed, .power_good_out,
    .power_good_oe, .overcurrent_protect, .overvoltage_protect,
    .thermal_shutdown);
  bsfs_plant i_bsfs_plant (.clock, .rst, .osc_half, .pwm_high,
    .power_good_out, .power_good_oe, .osc_clk, .pwm_on, .pg_pin);

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Clocks with the chosen gate high over a window
  task automatic count_hi(input int n, input logic hs, output logic [15:0] c);
    c = 16'h0000;
    repeat (n) begin
      @(negedge clock);
      if ((hs ? hs_gate : ls_gate) === 1'b1) c = c + 16'h0001;
    end
  endtask
  // Bounded wait for the high-side gate or the overcurrent flag to reach a level
  task automatic wait_for(input logic hs, input logic lvl, output int n);
    n = 0;
    while ((hs ? hs_gate : overcurrent_protect) !== lvl && n < 40000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task give_verdict;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    wt(10);
    cmp({drivers_enabled, ss_discharge, power_good_oe}, 16'h0003);
    @(posedge clock);
    vcc_ok <= 1'b1;
    enable_ok <= 1'b1;
    wt(12);
    cmp({drivers_enabled, ss_discharge, ref_fixed}, 16'h0005);
    count_hi(40, 1'b0, c1);
    cmp(c1, 16'h0000);
    // Pre-bias ramp: 3 of 8 clocks high, 5 off
    @(posedge clock);
    pwm_high <= 6'h03;
    wait_for(1'b1, 1'b1, k);
    count_hi(64, 1'b0, c1);
    wt(320);
    count_hi(64, 1'b0, c2);
    wt(64);
    count_hi(64, 1'b0, c3);
    cmp(c1 <= 16'h0018, 16'h0001);
    cmp(c2 > c1 && c2 < 16'h0028, 16'h0001);
    cmp(c3, 16'h0028);
    // Power good: delay level first, then 256 cycles in window
    @(posedge clock);
    pg_in_window <= 1'b1;
    wt(2400);
    cmp(power_good_oe, 16'h0001);
    @(posedge clock);
    ss_delay_reached <= 1'b1;
    wt(1600);
    cmp(power_good_oe, 16'h0001);
    wt(560);
    cmp({power_good_oe, pg_pin}, 16'h0001);
    @(posedge clock);
    pg_in_window <= 1'b0;
    wt(10);
    cmp({power_good_oe, pg_pin}, 16'h0002);
    @(posedge clock);
    temp_hot <= 1'b1;
    wt(10);
    cmp({thermal_shutdown, ss_discharge, hs_gate, ls_gate}, 16'h000C);
    @(posedge clock);
    temp_hot <= 1'b0;
    wt(10);
    cmp({thermal_shutdown, ss_discharge}, 16'h0000);
    // External soft-start pull-down, then release
    @(posedge clock);
    ss_below_low <= 1'b1;
    wt(10);
    count_hi(40, 1'b1, c1);
    cmp(c1, 16'h0000);
    @(posedge clock);
    ss_below_low <= 1'b0;
    wait_for(1'b1, 1'b1, k);
    cmp(k < 200, 16'h0001);
    @(posedge clock);
    ov_trip <= 1'b1;
    wt(10);
    cmp({hs_gate, ls_gate, overvoltage_protect}, 16'h0003);
    @(posedge clock);
    ov_trip <= 1'b0;
    wt(10);
    count_hi(40, 1'b1, c1);
    cmp({c1[7:0], ls_gate, overvoltage_protect}, 16'h0001);
    @(posedge clock);
    enable_ok <= 1'b0;
    wt(10);
    cmp({drivers_enabled, hs_gate, overvoltage_protect}, 16'h0000);
    @(posedge clock);
    enable_ok <= 1'b1;
    tracking_mode <= 1'b1;
    wt(10);
    cmp({drivers_enabled, ref_fixed}, 16'h0002);
    @(posedge clock);
    track_above_crossover <= 1'b1;
    wt(10);
    cmp(ref_fixed, 16'h0001);
    // Overcurrent: short low-side time is blanked, long one trips
    @(posedge clock);
    tracking_mode <= 1'b0;
    oc_below_gnd <= 1'b1;
    wt(200);
    cmp(overcurrent_protect, 16'h0000);
    @(posedge clock);
    osc_half <= 6'h18;
    pwm_high <= 6'h08;
    wait_for(1'b0, 1'b1, k);
    cmp(k < 2000, 16'h0001);
    @(posedge clock);
    osc_half <= 6'h04;
    pwm_high <= 6'h03;
    wt(1);
    cmp({ss_discharge, hs_gate, ls_gate}, 16'h0004);
    wait_for(1'b0, 1'b0, k);
    cmp(k > 32600 && k < 32900, 16'h0001);
    @(posedge clock);
    osc_half <= 6'h18;
    pwm_high <= 6'h08;
    wait_for(1'b0, 1'b1, k);
    cmp(k < 4000, 16'h0001);
    @(posedge clock);
    osc_half <= 6'h04;
    pwm_high <= 6'h03;
    oc_below_gnd <= 1'b0;
    wait_for(1'b0, 1'b0, k);
    wt(400);
    count_hi(64, 1'b1, c1);
    cmp({overcurrent_protect, ss_discharge, c1 != 0}, 16'h0001);
    give_verdict();
  end
endmodule
